/* File: design/sdcp_pkg.sv */
// Shared constants and types of the command and clock-enable port.
package sdcp_pkg;

    // Array organisation: four banks of 2,097,152 words of 32 bits.
    localparam int NUM_BANKS = 4;
    localparam int BANK_W    = 2;
    localparam int ROW_W     = 12;
    localparam int COL_W     = 9;
    localparam int DATA_W    = 32;
    localparam int LANES     = 4;
    localparam int LANE_W    = 8;
    localparam int PAIR_W    = COL_W - 1;
    localparam int WRAP_W    = 2;

    // Layout of the pin vector that runs through the synchroniser.
    localparam int P_CS     = 0;
    localparam int P_RAS    = 1;
    localparam int P_CAS    = 2;
    localparam int P_WE     = 3;
    localparam int P_SPARE  = 4;
    localparam int P_CKE    = 5;
    localparam int P_MIRROR = 6;
    localparam int P_BANK   = 7;
    localparam int P_ADDR   = P_BANK + BANK_W;
    localparam int P_DQR    = P_ADDR + ROW_W;
    localparam int P_DQF    = P_DQR + DATA_W;
    localparam int P_MKR    = P_DQF + DATA_W;
    localparam int P_MKF    = P_MKR + LANES;
    localparam int PIN_W    = P_MKF + LANES;

    // Address bits with a meaning of their own.
    localparam int AP_BIT      = 8;
    localparam int COL_HI_BIT  = 9;
    localparam int PAIR_HI_BIT = 7;
    localparam int PAIR_LO_BIT = 1;

    // Mode and extended mode fields.
    localparam logic [BANK_W-1:0] MODE_BANK = 2'h0;
    localparam logic [BANK_W-1:0] EXT_BANK  = 2'h1;
    localparam int MR_CL_LSB  = 0;
    localparam int MR_CL_W    = 4;
    localparam int MR_BL8_BIT = 4;
    localparam int EM_WL_LSB  = 0;
    localparam int EM_WL_W    = 3;
    localparam int EM_AL_BIT  = 3;

    // Latency limits and reset values, in clocks.
    localparam logic [3:0] CL_MIN  = 4'h4;
    localparam logic [3:0] CL_MAX  = 4'hB;
    localparam logic [3:0] CL_RST  = 4'h4;
    localparam logic [2:0] WL_MIN  = 3'h1;
    localparam logic [2:0] WL_MAX  = 3'h7;
    localparam logic [2:0] WL_RST  = 3'h1;
    localparam logic       AL_RST  = 1'b0;
    localparam logic       BL8_RST = 1'b0;

    // Pipeline stages already spent between pin and burst counter.
    localparam logic [3:0] RD_ADJ = 4'h2;
    localparam logic [3:0] WR_ADJ = 4'h1;

    // Clock pairs per burst: two beats travel in each clock.
    localparam logic [2:0] PAIRS_BL4 = 3'h2;
    localparam logic [2:0] PAIRS_BL8 = 3'h4;

    // Commands as {chip select, row, column, write} strobes.
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR  = 4'h4,
        CMD_RD  = 4'h5,
        CMD_NOP = 4'h7
    } sdcp_cmd_t;

    typedef enum logic [1:0] {
        PS_RUN  = 2'h0,
        PS_PPD  = 2'h1,
        PS_APD  = 2'h2,
        PS_SREF = 2'h3
    } sdcp_pwr_t;

endpackage

/* File: design/sdcp_store.sv */
// Storage array split into even and odd beat halves.
`timescale 1ns/1ps
module sdcp_store
    import sdcp_pkg::*;
#(
    parameter int ADDR_W = BANK_W + ROW_W + PAIR_W
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [DATA_W-1:0] wr_even_i,
    input  wire logic [DATA_W-1:0] wr_odd_i,
    input  wire logic [LANES-1:0]  be_even_i,
    input  wire logic [LANES-1:0]  be_odd_i,
    input  wire logic              rd_en_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [DATA_W-1:0] rd_even_o,
    output logic      [DATA_W-1:0] rd_odd_o
);

    typedef struct packed {
        logic [DATA_W-1:0] q_even;
        logic [DATA_W-1:0] q_odd;
    } sdcp_store_t;

    logic [DATA_W-1:0] mem_even [2**ADDR_W];
    logic [DATA_W-1:0] mem_odd  [2**ADDR_W];
    logic [DATA_W-1:0] old_even;
    logic [DATA_W-1:0] old_odd;
    logic [DATA_W-1:0] new_even;
    logic [DATA_W-1:0] new_odd;
    sdcp_store_t       st;
    sdcp_store_t       nx;

    assign old_even = mem_even[wr_addr_i];
    assign old_odd  = mem_odd[wr_addr_i];

    // A masked byte keeps its old contents, so each lane merges alone.
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign new_even[g*LANE_W +: LANE_W] = be_even_i[g] ?
            wr_even_i[g*LANE_W +: LANE_W] : old_even[g*LANE_W +: LANE_W];
        assign new_odd[g*LANE_W +: LANE_W] = be_odd_i[g] ?
            wr_odd_i[g*LANE_W +: LANE_W] : old_odd[g*LANE_W +: LANE_W];
    end

    // Merged words go back in one write per clock.
    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            mem_even[wr_addr_i] <= new_even;
            mem_odd[wr_addr_i]  <= new_odd;
        end
    end

    // Read data is registered so the pin outputs come from flops.
    always_comb begin
        nx = st;
        if (rd_en_i) begin
            nx.q_even = mem_even[rd_addr_i];
            nx.q_odd  = mem_odd[rd_addr_i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= nx;
        end
    end

    assign rd_even_o = st.q_even;
    assign rd_odd_o  = st.q_odd;

endmodule

/* File: design/sdcp_port.sv */
// Command, clock-enable and strobe port of a four-bank DDR DRAM.
`timescale 1ns/1ps
module sdcp_port
    import sdcp_pkg::*;
#(
    parameter int ROWS_W = ROW_W
) (
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                ce_i,
    input  wire logic                cs_n_i,
    input  wire logic                ras_n_i,
    input  wire logic                cas_n_i,
    input  wire logic                we_n_i,
    input  wire logic                spare_mirrored_input_i,
    input  wire logic                cke_i,
    input  wire logic                mirror_select_i,
    input  wire logic [BANK_W-1:0]   bank_select_i,
    input  wire logic [ROW_W-1:0]    addr_i,
    input  wire logic [DATA_W-1:0]   dq_rise_i,
    input  wire logic [DATA_W-1:0]   dq_fall_i,
    input  wire logic [LANES-1:0]    write_byte_mask_rise_i,
    input  wire logic [LANES-1:0]    write_byte_mask_fall_i,
    output logic      [DATA_W-1:0]   dq_rise_o,
    output logic      [DATA_W-1:0]   dq_fall_o,
    output logic                     dq_oe_o,
    output logic      [LANES-1:0]    read_strobe_o,
    output logic                     int_clk_en_o,
    output logic                     out_drv_en_o,
    output logic                     clk_rcv_en_o,
    output logic                     cmd_rcv_en_o,
    output logic                     cke_rcv_en_o,
    output logic                     spare_rcv_en_o,
    output logic      [1:0]          power_state_o,
    output logic      [NUM_BANKS-1:0] bank_open_o,
    output logic      [3:0]          read_latency_o,
    output logic      [2:0]          write_latency_o,
    output logic                     additive_latency_o,
    output logic                     burst8_o
);

    localparam int ADDR_W = BANK_W + ROWS_W + PAIR_W;

    typedef struct packed {
        logic [PIN_W-1:0]                 pin_s1;
        logic [PIN_W-1:0]                 pin_s2;
        logic                             cke_prev;
        sdcp_pwr_t                        pwr;
        logic [NUM_BANKS-1:0]             open;
        logic [NUM_BANKS-1:0][ROWS_W-1:0] row;
        logic [3:0]                       cl;
        logic [2:0]                       wl;
        logic                             al;
        logic                             bl8;
        logic [3:0]                       rd_wait;
        logic [2:0]                       rd_left;
        logic [WRAP_W-1:0]                rd_cnt;
        logic [BANK_W-1:0]                rd_bank;
        logic [PAIR_W-1:0]                rd_pair;
        logic                             rd_valid;
        logic [3:0]                       wr_wait;
        logic [2:0]                       wr_left;
        logic [WRAP_W-1:0]                wr_cnt;
        logic [BANK_W-1:0]                wr_bank;
        logic [PAIR_W-1:0]                wr_pair;
    } sdcp_state_t;

    sdcp_state_t       st;
    sdcp_state_t       nx;
    logic [PIN_W-1:0]  pins;
    logic              cke;
    logic              mirror;
    logic              ras_n;
    sdcp_cmd_t         cmd;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  addr;
    logic [PAIR_W-1:0] col_pair;
    logic              take;
    logic              rd_go;
    logic              wr_go;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] q_even;
    logic [DATA_W-1:0] q_odd;

    // Wrapped pair address within a burst; bursts start on an even beat.
    function automatic logic [PAIR_W-1:0] burst_pair(
        input logic [PAIR_W-1:0] base,
        input logic [WRAP_W-1:0] cnt,
        input logic              bl8);
        logic [WRAP_W-1:0] offs;
        offs = base[WRAP_W-1:0] + cnt;
        burst_pair = base;
        if (bl8) begin
            burst_pair[WRAP_W-1:0] = offs;
        end else begin
            burst_pair[0] = offs[0];
        end
    endfunction

    // Every pin is gathered into one vector for the two-flop synchroniser.
    assign pins[P_CS]                   = cs_n_i;
    assign pins[P_RAS]                  = ras_n_i;
    assign pins[P_CAS]                  = cas_n_i;
    assign pins[P_WE]                   = we_n_i;
    assign pins[P_SPARE]                = spare_mirrored_input_i;
    assign pins[P_CKE]                  = cke_i;
    assign pins[P_MIRROR]               = mirror_select_i;
    assign pins[P_BANK +: BANK_W]       = bank_select_i;
    assign pins[P_ADDR +: ROW_W]        = addr_i;
    assign pins[P_DQR +: DATA_W]        = dq_rise_i;
    assign pins[P_DQF +: DATA_W]        = dq_fall_i;
    assign pins[P_MKR +: LANES]         = write_byte_mask_rise_i;
    assign pins[P_MKF +: LANES]         = write_byte_mask_fall_i;

    // Decode reads only the second synchroniser stage.
    assign cke    = st.pin_s2[P_CKE];
    assign mirror = st.pin_s2[P_MIRROR];
    // With the mirror strap high the row strobe arrives on the other ball.
    assign ras_n  = mirror ? st.pin_s2[P_SPARE] : st.pin_s2[P_RAS];
    assign cmd    = sdcp_cmd_t'({st.pin_s2[P_CS], ras_n,
                                 st.pin_s2[P_CAS], st.pin_s2[P_WE]});
    assign bank   = st.pin_s2[P_BANK +: BANK_W];
    assign addr   = st.pin_s2[P_ADDR +: ROW_W];
    assign col_pair = {addr[COL_HI_BIT], addr[PAIR_HI_BIT:PAIR_LO_BIT]};

    // A command counts only while running, enabled both edges, and selected.
    assign take = (st.pwr == PS_RUN) && cke && st.cke_prev
                  && !st.pin_s2[P_CS];

    // Burst engines step once per clock, one pair of beats each step.
    assign rd_go = (st.rd_left != 3'h0) && (st.rd_wait == 4'h0);
    assign wr_go = (st.wr_left != 3'h0) && (st.wr_wait == 4'h0);

    // The open row of the bank supplies the row part of each address.
    assign rd_addr = {st.rd_bank, st.row[st.rd_bank],
                      burst_pair(st.rd_pair, st.rd_cnt, st.bl8)};
    assign wr_addr = {st.wr_bank, st.row[st.wr_bank],
                      burst_pair(st.wr_pair, st.wr_cnt, st.bl8)};

    // Next-state logic for the whole port.
    always_comb begin
        nx          = st;
        nx.pin_s1   = pins;
        nx.pin_s2   = st.pin_s1;
        nx.cke_prev = cke;
        nx.rd_valid = rd_go;

        // Bursts keep running on their own; the controller keeps the
        // clock enable high until they end, so power-down never cuts one.
        if (rd_go) begin
            nx.rd_left = st.rd_left - 3'h1;
            nx.rd_cnt  = st.rd_cnt + 2'h1;
        end else if (st.rd_left != 3'h0) begin
            nx.rd_wait = st.rd_wait - 4'h1;
        end
        if (wr_go) begin
            nx.wr_left = st.wr_left - 3'h1;
            nx.wr_cnt  = st.wr_cnt + 2'h1;
        end else if (st.wr_left != 3'h0) begin
            nx.wr_wait = st.wr_wait - 4'h1;
        end

        // Command execution; a new burst replaces one still pending.
        if (take) begin
            case (cmd)
                CMD_ACT: begin
                    nx.open[bank] = 1'b1;
                    nx.row[bank]  = addr[ROWS_W-1:0];
                end
                CMD_PRE: begin
                    if (addr[AP_BIT]) begin
                        nx.open = '0;
                    end else begin
                        nx.open[bank] = 1'b0;
                    end
                end
                CMD_RD: begin
                    nx.rd_wait = st.cl + {3'h0, st.al} - RD_ADJ;
                    nx.rd_left = st.bl8 ? PAIRS_BL8 : PAIRS_BL4;
                    nx.rd_cnt  = '0;
                    nx.rd_bank = bank;
                    nx.rd_pair = col_pair;
                    if (addr[AP_BIT]) begin
                        nx.open[bank] = 1'b0;
                    end
                end
                CMD_WR: begin
                    nx.wr_wait = {1'b0, st.wl} + {3'h0, st.al} - WR_ADJ;
                    nx.wr_left = st.bl8 ? PAIRS_BL8 : PAIRS_BL4;
                    nx.wr_cnt  = '0;
                    nx.wr_bank = bank;
                    nx.wr_pair = col_pair;
                    if (addr[AP_BIT]) begin
                        nx.open[bank] = 1'b0;
                    end
                end
                CMD_MRS: begin
                    // Out-of-range latencies are dropped, the old value stays.
                    if (bank == MODE_BANK) begin
                        if (addr[MR_CL_LSB +: MR_CL_W] >= CL_MIN &&
                            addr[MR_CL_LSB +: MR_CL_W] <= CL_MAX) begin
                            nx.cl = addr[MR_CL_LSB +: MR_CL_W];
                        end
                        nx.bl8 = addr[MR_BL8_BIT];
                    end else if (bank == EXT_BANK) begin
                        if (addr[EM_WL_LSB +: EM_WL_W] >= WL_MIN &&
                            addr[EM_WL_LSB +: EM_WL_W] <= WL_MAX) begin
                            nx.wl = addr[EM_WL_LSB +: EM_WL_W];
                        end
                        nx.al = addr[EM_AL_BIT];
                    end
                end
                default: begin
                    // Refresh and no-operation touch no port state here.
                end
            endcase
        end

        // Power states follow the synchronised clock enable.
        case (st.pwr)
            PS_RUN: begin
                if (st.cke_prev && !cke) begin
                    if (!st.pin_s2[P_CS] && cmd == CMD_REF) begin
                        nx.pwr = PS_SREF;
                    end else if (|st.open) begin
                        nx.pwr = PS_APD;
                    end else begin
                        nx.pwr = PS_PPD;
                    end
                end
            end
            PS_PPD, PS_APD: begin
                if (cke) begin
                    nx.pwr = PS_RUN;
                end
            end
            PS_SREF: begin
                // Exit needs no edge of the external clock pair: the
                // enable is watched on the internal clock alone.
                if (cke) begin
                    nx.pwr = PS_RUN;
                end
            end
            default: begin
                nx.pwr = PS_RUN;
            end
        endcase
    end

    // All port state, frozen while ce_i is low.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st     <= '0;
            st.cl  <= CL_RST;
            st.wl  <= WL_RST;
            st.al  <= AL_RST;
            st.bl8 <= BL8_RST;
        end else if (ce_i) begin
            st <= nx;
        end
    end

    // Even words carry the rising beat, odd words the falling beat.
    sdcp_store #(
        .ADDR_W    (ADDR_W)
    ) u_store (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .wr_en_i   (wr_go),
        .wr_addr_i (wr_addr),
        .wr_even_i (st.pin_s2[P_DQR +: DATA_W]),
        .wr_odd_i  (st.pin_s2[P_DQF +: DATA_W]),
        .be_even_i (~st.pin_s2[P_MKR +: LANES]),
        .be_odd_i  (~st.pin_s2[P_MKF +: LANES]),
        .rd_en_i   (rd_go),
        .rd_addr_i (rd_addr),
        .rd_even_o (q_even),
        .rd_odd_o  (q_odd)
    );

    // Read beats and strobes leave from the same registered stage.
    assign dq_rise_o     = q_even;
    assign dq_fall_o     = q_odd;
    assign dq_oe_o       = st.rd_valid;
    assign read_strobe_o = {LANES{st.rd_valid}};

    // Receiver and driver enables; the spare ball is never received.
    assign int_clk_en_o   = (st.pwr == PS_RUN);
    assign out_drv_en_o   = (st.pwr == PS_RUN);
    assign cmd_rcv_en_o   = (st.pwr == PS_RUN);
    assign clk_rcv_en_o   = (st.pwr != PS_SREF);
    assign cke_rcv_en_o   = 1'b1;
    assign spare_rcv_en_o = 1'b0;

    // Status for the surrounding logic.
    assign power_state_o      = st.pwr;
    assign bank_open_o        = st.open;
    assign read_latency_o     = st.cl;
    assign write_latency_o    = st.wl;
    assign additive_latency_o = st.al;
    assign burst8_o           = st.bl8;

endmodule

/* File: bench/sdcp_port_assertions.sv */
// Port-level assertions of the command and clock-enable port.
`timescale 1ns/1ps
module sdcp_port_chk
    import sdcp_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 reset_n_i,
    input wire logic                 cs_n_i,
    input wire logic                 cke_i,
    input wire logic                 dq_oe_o,
    input wire logic [LANES-1:0]     read_strobe_o,
    input wire logic                 int_clk_en_o,
    input wire logic                 out_drv_en_o,
    input wire logic                 cmd_rcv_en_o,
    input wire logic                 clk_rcv_en_o,
    input wire logic                 cke_rcv_en_o,
    input wire logic                 spare_rcv_en_o,
    input wire logic [1:0]           power_state_o,
    input wire logic [NUM_BANKS-1:0] bank_open_o,
    input wire logic                 burst8_o
);
    // All checks run on the device clock and rest during reset.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // A burst holds the bus for half its beats in clocks, then frees it.
    sequence s_bl4; dq_oe_o [*2] ##1 !dq_oe_o; endsequence
    sequence s_bl8; dq_oe_o [*4] ##1 !dq_oe_o; endsequence
    property p_bl4; $rose(dq_oe_o) && !burst8_o |-> s_bl4; endproperty
    property p_bl8; $rose(dq_oe_o) && burst8_o |-> s_bl8; endproperty
    // Strobes stay high for as long as the data, so they follow the valid flag.
    property p_strb; read_strobe_o == {LANES{dq_oe_o}}; endproperty
    // Clocks, drivers and command receivers run only when awake.
    property p_run; {int_clk_en_o, out_drv_en_o, cmd_rcv_en_o}
        == {3{power_state_o == PS_RUN}}; endproperty
    // The clock pair is dropped only in self refresh; the spare never runs.
    property p_rcv; cke_rcv_en_o && !spare_rcv_en_o
        && clk_rcv_en_o == (power_state_o != PS_SREF); endproperty
    // Open rows decide between active and precharge power-down.
    property p_kind; $past(power_state_o) == PS_RUN
        && power_state_o inside {PS_PPD, PS_APD}
        |-> (power_state_o == PS_APD) == |$past(bank_open_o); endproperty
    // Dropping clock enable while awake leaves run state within 5 clocks.
    property p_fall; $fell(cke_i) && power_state_o == PS_RUN
        |-> ##[1:5] power_state_o != PS_RUN; endproperty
    // Deselected pins leave the open-row map untouched.
    property p_cs; cs_n_i [*4] |-> ##2 $stable(bank_open_o); endproperty

    a_bl4: assert property (p_bl4) else $error("burst of 4 broken");
    a_bl8: assert property (p_bl8) else $error("burst of 8 broken");
    a_strb: assert property (p_strb) else $error("strobe off data");
    a_run: assert property (p_run) else $error("run enables wrong");
    a_rcv: assert property (p_rcv) else $error("receivers wrong");
    a_kind: assert property (p_kind) else $error("wrong sleep kind");
    a_fall: assert property (p_fall) else $error("no sleep entry");
    a_cs: assert property (p_cs) else $error("deselect not masked");
endmodule

bind sdcp_port sdcp_port_chk chk_u (
    .clk_i, .reset_n_i, .cs_n_i, .cke_i, .dq_oe_o, .read_strobe_o,
    .int_clk_en_o, .out_drv_en_o, .cmd_rcv_en_o, .clk_rcv_en_o,
    .cke_rcv_en_o, .spare_rcv_en_o, .power_state_o, .bank_open_o, .burst8_o
);

/* File: bench/sdcp_ctl_model.sv */
// Memory controller model: drives commands, clock enable and write data.
`timescale 1ns/1ps
module sdcp_ctl_model
    import sdcp_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         mirror_i,
    output logic [4:0]        cmd_o,
    output logic              cke_o,
    output logic [BANK_W-1:0] bank_o,
    output logic [ROW_W-1:0]  addr_o,
    output logic [63:0]       dq_o,
    output logic [7:0]        mk_o
);
    // Idle bus: deselected, clock enable high, data lines junk.
    initial begin
        cmd_o = 5'h1F;
        cke_o = 1'b1;
        bank_o = 2'h0;
        addr_o = 12'h000;
        dq_o = 64'h0;
        mk_o = 8'h00;
    end

    // One command; write data follows lat clocks later for np pairs.
    // Released lines flip every clock so a stale beat cannot pass.
    task automatic op(input logic [3:0] c, input logic [1:0] b,
        input logic [11:0] a, input int lat, input int np,
        input logic [31:0] base, input logic [7:0] mr, input logic ck);
        @(posedge clk_i);
        cke_o <= ck;
        cmd_o <= {c[3], mirror_i ^ c[2], c[1:0], ~(mirror_i ^ c[2])};
        bank_o <= b;
        addr_o <= a;
        for (int k = 1; k <= lat + np + 1; k++) begin
            @(posedge clk_i);
            cmd_o <= 5'h1F;
            addr_o <= ~addr_o;
            if (k >= lat && k < lat + np) begin
                dq_o[63:32] <= base + 32'(2 * (k - lat));
                dq_o[31:0] <= base + 32'(2 * (k - lat) + 1);
                mk_o <= mr;
            end else begin
                dq_o <= ~dq_o;
                mk_o <= ~mk_o;
            end
        end
    endtask
endmodule

/* File: bench/tb_sdcp_port.sv */
// Self-checking testbench of the command and clock-enable port.
`timescale 1ns/1ps
module tb_sdcp_port
    import sdcp_pkg::*;
;
    logic        clk, rst_n, mirror, cke, oe, al, bl8;
    logic [4:0]  pins;
    logic [1:0]  bank, pst;
    logic [11:0] addr;
    logic [63:0] dq;
    logic [7:0]  mk;
    logic [31:0] rr, rf;
    logic [3:0]  strb, bopen, cl;
    logic [2:0]  wl;
    wire  [5:0]  en;
    logic [31:0] er [4];
    logic [31:0] ef [4];
    int          error_cnt = 0;
    int          n_tests = 0;

    // Free-running 20 MHz device clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    sdcp_ctl_model u_ctl (.clk_i(clk), .mirror_i(mirror), .cmd_o(pins),
        .cke_o(cke), .bank_o(bank), .addr_o(addr), .dq_o(dq), .mk_o(mk));
    sdcp_port #(.ROWS_W(4)) dut_u (
        .clk_i(clk), .reset_n_i(rst_n), .ce_i(1'b1), .cs_n_i(pins[4]),
        .ras_n_i(pins[3]), .cas_n_i(pins[2]), .we_n_i(pins[1]),
        .spare_mirrored_input_i(pins[0]), .cke_i(cke),
        .mirror_select_i(mirror), .bank_select_i(bank), .addr_i(addr),
        .dq_rise_i(dq[63:32]), .dq_fall_i(dq[31:0]),
        .write_byte_mask_rise_i(mk[7:4]), .write_byte_mask_fall_i(mk[3:0]),
        .dq_rise_o(rr), .dq_fall_o(rf), .dq_oe_o(oe), .read_strobe_o(strb),
        .int_clk_en_o(en[5]), .out_drv_en_o(en[4]), .cmd_rcv_en_o(en[3]),
        .clk_rcv_en_o(en[2]), .cke_rcv_en_o(en[1]), .spare_rcv_en_o(en[0]),
        .power_state_o(pst), .bank_open_o(bopen), .read_latency_o(cl),
        .write_latency_o(wl), .additive_latency_o(al), .burst8_o(bl8));

    // Counts one comparison and reports a difference at once.
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Waits n clocks and lets that edge settle before sampling.
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Sends a command and waits until its effect must be visible.
    task automatic cmd(input logic [3:0] c, input logic [1:0] b,
        input logic [11:0] a, input logic k);
        u_ctl.op(c, b, a, 0, 0, 32'h0, 8'h00, k);
        wt(4);
    endtask

    // Expected power state and the enables that follow from it.
    task automatic chk_pwr(input logic [1:0] st);
        chk("power state", st, pst);
        chk("enables", {{3{st == 2'h0}}, st != 2'h3, 2'b10}, en);
    endtask

    // Reads bank 2; checks latency in clocks, every pair and the strobe.
    task automatic rd(input logic [11:0] a, input int lat, input int np);
        int n;
        n = 1;
        u_ctl.op(CMD_RD, 2'h2, a, 0, 0, 32'h0, 8'h00, 1'b1);
        while (oe !== 1'b1 && n < 40) begin
            wt(1);
            n++;
        end
        if (n >= 40) begin
            error_cnt++;
            final_report();
        end
        chk("read latency", lat, n);
        for (int i = 0; i < np; i++) begin
            chk("rise beat", er[i], rr);
            chk("fall beat", ef[i], rf);
            chk("strobe", 4'hF, strb);
            wt(1);
        end
        chk("burst end", 1'b0, oe);
    endtask

    // Main sequence: reset, latency sweeps, data, banks, power states.
    initial begin
        rst_n = 1'b0;
        mirror = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wt(1);
        chk("read latency", CL_RST, cl);
        chk("write latency", WL_RST, wl);
        chk("al and bl8", 2'b00, {al, bl8});
        chk_pwr(2'h0);
        for (int i = 4; i <= 12; i++) begin
            cmd(CMD_MRS, MODE_BANK, 12'(i), 1'b1);
            chk("read latency", (i > 11) ? 11 : i, cl);
        end
        for (int i = 1; i <= 8; i++) begin
            cmd(CMD_MRS, EXT_BANK, 12'(i), 1'b1);
            chk("write latency", (i > 7) ? 7 : i, wl);
            chk("additive latency", i > 7, al);
        end
        cmd(CMD_MRS, MODE_BANK, 12'h004, 1'b1);
        cmd(CMD_MRS, EXT_BANK, 12'h001, 1'b1);
        cmd(CMD_ACT, 2'h2, 12'h003, 1'b1);
        chk("open banks", 4'h4, bopen);
        // Second write masks rise lane 0 and fall lane 1 of each pair.
        u_ctl.op(CMD_WR, 2'h2, 12'h000, 1, 2, 32'hA0A0A010, 8'h00, 1'b1);
        u_ctl.op(CMD_WR, 2'h2, 12'h000, 1, 2, 32'h5B5B5B40, 8'h12, 1'b1);
        for (int i = 0; i < 2; i++) begin
            er[i] = 32'h5B5B5B10 + 32'(2 * i);
            ef[i] = 32'h5B5BA041 + 32'(2 * i);
        end
        // First data pair shows CL + AL clocks after decode, two sync stages.
        rd(12'h000, 6, 2);
        cmd(CMD_MRS, MODE_BANK, 12'h015, 1'b1);
        chk("burst 8", 1'b1, bl8);
        cmd(CMD_MRS, EXT_BANK, 12'h00A, 1'b1);
        u_ctl.op(CMD_WR, 2'h2, 12'h008, 3, 4, 32'hC0C0C000, 8'h00, 1'b1);
        // Starting in the third pair, the burst wraps as 2, 3, 0, 1.
        for (int i = 0; i < 4; i++) begin
            er[i] = 32'hC0C0C000 + 32'(2 * ((i + 2) % 4));
            ef[i] = er[i] + 32'h1;
        end
        rd(12'h00C, 8, 4);
        cmd(4'hB, 2'h1, 12'h003, 1'b1);
        chk("open banks", 4'h4, bopen);
        @(posedge clk) mirror <= 1'b1;
        cmd(CMD_ACT, 2'h1, 12'h003, 1'b1);
        chk("open banks", 4'h6, bopen);
        @(posedge clk) mirror <= 1'b0;
        cmd(CMD_PRE, 2'h2, 12'h000, 1'b1);
        chk("open banks", 4'h2, bopen);
        cmd(CMD_PRE, 2'h0, 12'h100, 1'b1);
        chk("open banks", 4'h0, bopen);
        cmd(CMD_NOP, 2'h0, 12'h000, 1'b0);
        chk_pwr(2'h1);
        cmd(CMD_NOP, 2'h0, 12'h000, 1'b1);
        chk_pwr(2'h0);
        cmd(CMD_ACT, 2'h3, 12'h001, 1'b1);
        cmd(CMD_NOP, 2'h0, 12'h000, 1'b0);
        chk_pwr(2'h2);
        cmd(CMD_NOP, 2'h0, 12'h000, 1'b1);
        cmd(CMD_PRE, 2'h0, 12'h100, 1'b1);
        cmd(CMD_REF, 2'h0, 12'h000, 1'b0);
        chk_pwr(2'h3);
        cmd(CMD_NOP, 2'h0, 12'h000, 1'b1);
        chk_pwr(2'h0);
        final_report();
    end
endmodule
